// ===== logic/flcc_top.v
/*
 * host controller that clears all block lock bits of a parallel flash,
 * reads and clears its status, and drives reset/power-down.
 * assumes an 8-bit flash data bus, pins asynchronous to clk,
 * and software ordering its orders over axi4-lite.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
// Functional notes
// RULE1 - clear locks: write 60 then D0
// RULE2 - write 70 to read status register
// RULE3 - status bit 7 high means ready
// RULE4 - write FF after clear to read array
// RULE5 - supply error sets bit 3 plus 4/5
// RULE6 - permanent lock refuses clear, sets bit 1
// RULE7 - bits 4 and 5 mean bad sequence
// RULE8 - bit 5 flags lock clear failure
// RULE9 - error bits stick until clear status
// RULE10 - clear status before any retry
// RULE11 - ready/busy low while operation runs
// RULE12 - ready/busy floats in suspend, reset
// RULE13 - reset during operation keeps busy low
// RULE14 - reset aborts operation, enters reset mode
// RULE15 - reissue whole sequence after reset abort
// RULE16 - reset pin low clears status register
// RULE17 - command latch ignores supply, select changes
// RULE18 - array read after power-up, reset exit
// RULE19 - write only with select and strobe low
// RULE20 - modify needs setup then confirm
// RULE21 - reset pin low disables device
// RULE22 - poll ready before errors or next
`timescale 1ns/10ps
`include "flcc_defines.vh"
module flcc_top (
	// clock and reset
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	// axi4-lite write
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// flash control pins
	output reg flash_ce_n,
	output reg flash_we_n,
	output reg flash_oe_n,
	output reg reset_powerdown_n_pin,
	// flash data bus
	input wire [7:0] flash_dq_in,
	output reg [7:0] flash_dq_out,
	output reg flash_dq_oe,
	// flash ready/busy, open drain with pull-up
	input wire ready_busy_n_pin
);

// ***************************
// states
// ***************************
localparam ST_IDLE = 4'h0;
localparam ST_WR_LOW = 4'h1;
localparam ST_WR_HIGH = 4'h2;
localparam ST_WAIT_RB = 4'h3;
localparam ST_RD_LOW = 4'h4;
localparam ST_RD_HIGH = 4'h5;
localparam ST_RESET = 4'h6;
localparam ST_NEXT = 4'h7;

// step codes for the command sequencer
localparam SP_SETUP = 3'h0;
localparam SP_CONFIRM = 3'h1;
localparam SP_POLL = 3'h2;
localparam SP_ARRAY = 3'h3;
localparam SP_SINGLE = 3'h4;
localparam SP_STATUS_RD = 3'h5;
localparam SP_DONE = 3'h6;

reg [3:0] state;
reg [2:0] step;
reg [3:0] count;
reg [1:0] op;
reg busy;
reg seq_err;
reg [7:0] flash_status;
reg [7:0] cmd_byte;

wire wr_pulse;
wire [3:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire rb_sync;

wire [31:0] rd_ctrl = {29'h00000000, op, busy};
wire flash_err = flash_status[`FLCC_SR_LOCK_CLEAR_ERR] | flash_status[`FLCC_SR_WRITE_ERR]
	| flash_status[`FLCC_SR_SUPPLY_ERR] | flash_status[`FLCC_SR_PROTECT];
wire [31:0] rd_stat = {28'h0000000, seq_err, flash_err, rb_sync, busy};
wire [31:0] rd_fstat = {24'h000000, flash_status};
wire [31:0] rd_wdata = {24'h000000, cmd_byte};
// byte for the next write, on the pins together with the falling strobe
wire [7:0] next_cmd = (step == SP_SETUP) ? `FLCC_CMD_LOCK_SETUP // RULE1 RULE20
	: (step == SP_CONFIRM) ? `FLCC_CMD_CLEAR_CONFIRM // RULE1 RULE20
	: (step == SP_POLL) ? `FLCC_CMD_READ_STATUS // RULE2
	: (step == SP_ARRAY) ? `FLCC_CMD_READ_ARRAY : cmd_byte; // RULE4

wire ctrl_write = wr_pulse & (wr_addr == `FLCC_REG_CTRL) & wr_strb[0];
wire go = ctrl_write & wr_data[`FLCC_CTRL_GO];
wire rst_req = ctrl_write & wr_data[`FLCC_CTRL_RST];

// ***************************
// register bus and pin synchroniser
// ***************************
flcc_axil u_axil (
	.clk(clk),
	.rst_b(rst_b),
	.clk_en(clk_en),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.wr_pulse(wr_pulse),
	.wr_addr(wr_addr),
	.wr_data(wr_data),
	.wr_strb(wr_strb),
	.rd_ctrl(rd_ctrl),
	.rd_stat(rd_stat),
	.rd_fstat(rd_fstat),
	.rd_wdata(rd_wdata)
);

// pulled-up pin idles high, so a floating line reads as ready
flcc_sync #(.RESET_VAL(1'b1)) u_rb_sync (
	.clk(clk),
	.rst_b(rst_b),
	.clk_en(clk_en),
	.pin_in(ready_busy_n_pin),
	.pin_sync(rb_sync)
);

// data bus is sampled only after the read strobe has been low for
// several cycles; two flops still guard the read value
reg [7:0] dq_meta;
reg [7:0] dq_sync;
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		dq_meta <= 8'h00;
		dq_sync <= 8'h00;
	end else if (clk_en) begin
		dq_meta <= flash_dq_in;
		dq_sync <= dq_meta;
	end
end

// ***************************
// command sequencer
// ***************************
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		state <= ST_IDLE;
		step <= SP_DONE;
		count <= 4'h0;
		op <= `FLCC_OP_CLEAR_LOCKS;
		busy <= 1'b0;
		seq_err <= 1'b0;
		flash_status <= 8'h00;
		cmd_byte <= 8'h00;
		flash_ce_n <= 1'b1;
		flash_we_n <= 1'b1;
		flash_oe_n <= 1'b1;
		flash_dq_out <= 8'h00;
		flash_dq_oe <= 1'b0;
		reset_powerdown_n_pin <= 1'b0;
	end else if (clk_en) begin
		case (state)
			ST_IDLE: begin
				reset_powerdown_n_pin <= 1'b1;
				if (go) begin
					op <= wr_data[`FLCC_CTRL_OP_MSB:`FLCC_CTRL_OP_LSB];
					busy <= 1'b1;
					seq_err <= 1'b0;
					state <= ST_NEXT;
					case (wr_data[`FLCC_CTRL_OP_MSB:`FLCC_CTRL_OP_LSB])
						`FLCC_OP_CLEAR_LOCKS: begin
							// refuse while the flash still reports busy or a stale error
							if (!rb_sync | flash_err) begin // RULE10 RULE22
								seq_err <= 1'b1;
								busy <= 1'b0;
								state <= ST_IDLE;
							end
							step <= SP_SETUP;
						end
						`FLCC_OP_CLEAR_STATUS: begin
							cmd_byte <= `FLCC_CMD_CLEAR_STATUS;
							flash_status <= 8'h00; // RULE9
							step <= SP_SINGLE;
						end
						`FLCC_OP_READ_STATUS: step <= SP_POLL; // RULE2
						default: step <= SP_ARRAY;
					endcase
				end
			end
			ST_NEXT: begin
				// issue the command byte chosen by the step
				cmd_byte <= next_cmd;
				if (step == SP_DONE) begin
					busy <= 1'b0;
					state <= ST_IDLE;
				end else if (step == SP_STATUS_RD) begin
					flash_ce_n <= 1'b0;
					flash_oe_n <= 1'b0;
					count <= `FLCC_STROBE_CYC;
					state <= ST_RD_LOW;
				end else begin
					flash_ce_n <= 1'b0; // RULE19
					flash_we_n <= 1'b0; // RULE19
					flash_dq_oe <= 1'b1;
					flash_dq_out <= next_cmd;
					count <= `FLCC_STROBE_CYC;
					state <= ST_WR_LOW;
				end
			end
			ST_WR_LOW: begin
				flash_dq_out <= cmd_byte;
				if (count == 4'h0) begin
					// rising strobe latches the command
					flash_we_n <= 1'b1;
					count <= `FLCC_STROBE_CYC;
					state <= ST_WR_HIGH;
				end else begin
					count <= count - 4'h1;
				end
			end
			ST_WR_HIGH: begin
				flash_ce_n <= 1'b1;
				if (count == 4'h0) begin
					flash_dq_oe <= 1'b0;
					state <= ST_NEXT;
					case (step)
						SP_SETUP: step <= SP_CONFIRM;
						SP_CONFIRM: begin
							step <= SP_POLL;
							state <= ST_WAIT_RB;
						end
						SP_POLL: step <= SP_STATUS_RD;
						default: step <= SP_DONE;
					endcase
				end else begin
					count <= count - 4'h1;
				end
			end
			ST_WAIT_RB: begin
				// line goes low once the operation starts, then releases
				if (rb_sync) // RULE11
					state <= ST_NEXT;
			end
			ST_RD_LOW: begin
				if (count == 4'h0) begin
					// busy flash: keep polling until ready
					if (!dq_sync[`FLCC_SR_READY]) begin // RULE3
						flash_status <= dq_sync;
					end else begin
						// error bits accumulate until cleared
						flash_status <= flash_status | dq_sync; // RULE9 RULE5 RULE6 RULE7 RULE8
					end
					flash_oe_n <= 1'b1;
					flash_ce_n <= 1'b1;
					count <= `FLCC_STROBE_CYC;
					state <= ST_RD_HIGH;
				end else begin
					count <= count - 4'h1;
				end
			end
			ST_RD_HIGH: begin
				if (count == 4'h0) begin
					state <= ST_NEXT;
					if (!flash_status[`FLCC_SR_READY])
						step <= SP_STATUS_RD; // RULE22
					else if (op == `FLCC_OP_CLEAR_LOCKS)
						step <= SP_ARRAY; // RULE4
					else
						step <= SP_DONE;
					flash_status[`FLCC_SR_READY] <= flash_status[`FLCC_SR_READY];
				end else begin
					count <= count - 4'h1;
				end
			end
			ST_RESET: begin
				// reset pin low clears flash status and aborts its operation
				flash_status <= 8'h00; // RULE16 RULE14
				flash_ce_n <= 1'b1;
				flash_we_n <= 1'b1;
				flash_oe_n <= 1'b1;
				flash_dq_oe <= 1'b0;
				if (count == 4'h0) begin
					reset_powerdown_n_pin <= 1'b1; // RULE18
					busy <= 1'b0;
					state <= ST_IDLE; // RULE15
				end else begin
					count <= count - 4'h1;
				end
			end
			default: state <= ST_IDLE;
		endcase
		// reset order wins in any state, so a running operation can be aborted
		if (rst_req) begin
			reset_powerdown_n_pin <= 1'b0; // RULE21
			count <= `FLCC_RESET_CYC;
			busy <= 1'b1;
			state <= ST_RESET;
		end
	end
end

endmodule

// ===== logic/flcc_defines.vh
/*
 * constants for the flash lock-clear host controller: register offsets,
 * command codes, status bit positions, bus timing counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef FLCC_DEFINES_VH
`define FLCC_DEFINES_VH

// ***************************
// controller register offsets
// ***************************
`define FLCC_REG_CTRL 4'h0
`define FLCC_REG_STAT 4'h4
`define FLCC_REG_FSTAT 4'h8
`define FLCC_REG_WDATA 4'hC

// ***************************
// control register fields
// ***************************
`define FLCC_CTRL_GO 0
`define FLCC_CTRL_OP_LSB 1
`define FLCC_CTRL_OP_MSB 2
`define FLCC_CTRL_RST 3

// operation codes
`define FLCC_OP_CLEAR_LOCKS 2'h0
`define FLCC_OP_CLEAR_STATUS 2'h1
`define FLCC_OP_READ_STATUS 2'h2
`define FLCC_OP_READ_ARRAY 2'h3

// ***************************
// flash command codes
// ***************************
`define FLCC_CMD_LOCK_SETUP 8'h60
`define FLCC_CMD_CLEAR_CONFIRM 8'hD0
`define FLCC_CMD_READ_STATUS 8'h70
`define FLCC_CMD_CLEAR_STATUS 8'h50
`define FLCC_CMD_READ_ARRAY 8'hFF

// ***************************
// flash status bits
// ***************************
`define FLCC_SR_READY 7
`define FLCC_SR_LOCK_CLEAR_ERR 5
`define FLCC_SR_WRITE_ERR 4
`define FLCC_SR_SUPPLY_ERR 3
`define FLCC_SR_PROTECT 1

// ***************************
// bus timing, in ns and in clk cycles at 25 MHz
// ***************************
`define FLCC_CLK_NS 40
`define FLCC_STROBE_NS 100
`define FLCC_STROBE_CYC 4'h3
`define FLCC_RESET_NS 200
`define FLCC_RESET_CYC 4'h5

// ***************************
// controller status register bits
// ***************************
`define FLCC_STAT_BUSY 0
`define FLCC_STAT_FLASH_READY 1
`define FLCC_STAT_ERROR 2
`define FLCC_STAT_SEQ_ERR 3

`endif

// ===== logic/flcc_sync.v
/*
 * two-flop synchroniser for one asynchronous level.
 * assumes the input is a device pin outside the clk domain.
 */
`timescale 1ns/10ps
module flcc_sync #(
	parameter RESET_VAL = 1'b1
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	// level
	input wire pin_in,
	output reg pin_sync
);

reg stage1;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		stage1 <= RESET_VAL;
		pin_sync <= RESET_VAL;
	end else if (clk_en) begin
		stage1 <= pin_in;
		pin_sync <= stage1;
	end
end

endmodule

// ===== logic/flcc_axil.v
/*
 * axi4-lite slave for the controller registers.
 * assumes the master keeps one write and one read in flight at most.
 * write: aw and w taken in any order; bvalid one cycle after both.
 * read: rdata registered, rvalid one cycle after ar taken.
 */
`timescale 1ns/10ps
`include "flcc_defines.vh"
module flcc_axil (
	// clock and reset
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	// write address and data
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// read
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// register side
	output reg wr_pulse,
	output reg [3:0] wr_addr,
	output reg [31:0] wr_data,
	output reg [3:0] wr_strb,
	input wire [31:0] rd_ctrl,
	input wire [31:0] rd_stat,
	input wire [31:0] rd_fstat,
	input wire [31:0] rd_wdata
);

reg aw_held;
reg w_held;
wire aw_take = s_axi_awvalid & s_axi_awready;
wire w_take = s_axi_wvalid & s_axi_wready;
wire aw_now = aw_held | aw_take;
wire w_now = w_held | w_take;
// the address taken in this very cycle decides the response
wire [3:0] wr_addr_now = aw_take ? s_axi_awaddr : wr_addr;
wire wr_mapped = (wr_addr_now[1:0] == 2'h0);

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
		aw_held <= 1'b0;
		w_held <= 1'b0;
		wr_pulse <= 1'b0;
		wr_addr <= 4'h0;
		wr_data <= 32'h00000000;
		wr_strb <= 4'h0;
	end else if (clk_en) begin
		wr_pulse <= 1'b0;
		if (aw_take) begin
			wr_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		if (w_take) begin
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		if (aw_now & w_now & !s_axi_bvalid) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_pulse <= 1'b1;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
		end else begin
			aw_held <= aw_now;
			w_held <= w_now;
		end
		if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'h0;
	end else if (clk_en) begin
		if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
				`FLCC_REG_CTRL: s_axi_rdata <= rd_ctrl;
				`FLCC_REG_STAT: s_axi_rdata <= rd_stat;
				`FLCC_REG_FSTAT: s_axi_rdata <= rd_fstat;
				`FLCC_REG_WDATA: s_axi_rdata <= rd_wdata;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule

// ===== sim/flcc_top_assertions.sv
/*
 * checker on the flash pins of flcc_top.
 * assumes a bind into flcc_top and one clock domain.
 */
`timescale 1ns/10ps
module flcc_chk (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// flash pins
	input wire flash_ce_n,
	input wire flash_we_n,
	input wire flash_oe_n,
	input wire [7:0] flash_dq_in,
	input wire [7:0] flash_dq_out,
	input wire flash_dq_oe,
	input wire reset_powerdown_n_pin,
	input wire ready_busy_n_pin
);
	reg we_q;
	reg oe_q;
	reg clr_pend;
	reg err_seen;
	reg [7:0] dq_q;
	reg [7:0] last_cmd;
	wire we_up = flash_we_n & ~we_q & ~flash_ce_n;
	// dq_q still holds the byte read before oe rose
	wire rd_end = flash_oe_n & ~oe_q;
	wire bad = rd_end & (|dq_q[5:3] | dq_q[1]);
	// ****************
	// command history
	// ****************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			we_q <= 1'b1;
			oe_q <= 1'b1;
			clr_pend <= 1'b0;
			err_seen <= 1'b0;
			dq_q <= 8'h00;
			last_cmd <= 8'h00;
		end else begin
			we_q <= flash_we_n;
			oe_q <= flash_oe_n;
			dq_q <= flash_dq_in;
			if (we_up) last_cmd <= flash_dq_out;
			if (we_up && flash_dq_out == 8'hD0) clr_pend <= 1'b1;
			else if (we_up && flash_dq_out == 8'hFF) clr_pend <= 1'b0;
			if (bad) err_seen <= 1'b1;
			else if (we_up && flash_dq_out == 8'h50) err_seen <= 1'b0;
			// reset pin wipes flash status and aborts any sequence
			if (!reset_powerdown_n_pin) begin
				clr_pend <= 1'b0;
				err_seen <= 1'b0;
				last_cmd <= 8'h00;
			end
		end
	end
	// ****************
	// properties
	// ****************
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence cmd_s(logic [7:0] c);
		$rose(flash_we_n) && !flash_ce_n && flash_dq_out == c;
	endsequence
	we_needs_ce_a: assert property (!flash_we_n |-> !flash_ce_n)
		else $error("strobe without select");
	dq_held_a: assert property (!flash_we_n && !$past(flash_we_n)
		|-> $stable(flash_dq_out) && flash_dq_oe) else $error("command byte moved");
	confirm_next_a: assert property (cmd_s(8'h60) |-> ##[1:30] cmd_s(8'hD0))
		else $error("no confirm after setup");
	setup_first_a: assert property (cmd_s(8'hD0) |-> last_cmd == 8'h60)
		else $error("confirm without setup");
	status_next_a: assert property ($rose(flash_we_n) && last_cmd == 8'hD0
		|-> flash_dq_out == 8'h70) else $error("no status read after confirm");
	array_after_a: assert property (rd_end && dq_q[7] && clr_pend
		|-> ##[1:30] cmd_s(8'hFF)) else $error("no array read after clear");
	clear_first_a: assert property (cmd_s(8'h60) |-> !err_seen)
		else $error("retry with error pending");
	idle_write_a: assert property ($fell(flash_we_n) |-> ready_busy_n_pin)
		else $error("command while flash busy");
endmodule

bind flcc_top flcc_chk u_chk (.clk(clk), .rst_b(rst_b), .flash_ce_n(flash_ce_n),
	.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_dq_in(flash_dq_in),
	.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
	.reset_powerdown_n_pin(reset_powerdown_n_pin),
	.ready_busy_n_pin(ready_busy_n_pin));

// ===== sim/flcc_flash_model.sv
/*
 * behavioural flash: command latch, status byte, ready/busy.
 * assumes pins change on clk edges; clk samples the strobe and paces the busy time.
 */
`timescale 1ns/10ps
module flcc_flash #(
	parameter BUSY = 40
) (
	// pacing clock
	input wire clk,
	// control pins
	input wire ce_n,
	input wire we_n,
	input wire oe_n,
	input wire rp_n,
	// data, fault 0 none 1 supply 2 perm lock 3 fail
	input wire [7:0] dq,
	input wire [1:0] fault,
	output wire [7:0] dq_rd,
	output wire rb_low
);
	reg we_d = 1'b1;
	reg setup = 1'b0;
	reg stat = 1'b0;
	reg aborted = 1'b0;
	reg [7:0] sr = 8'h00;
	reg [31:0] log = 32'h0;
	integer cnt = 0;
	wire [7:0] rd = stat ? {cnt == 0, sr[6:0]} : 8'h00;
	wire [7:0] err = fault == 2'h1 ? 8'h28 : fault == 2'h2 ? 8'h02 : {2'h0, fault[0], 5'h0};
	// released bus never shows a stale byte
	assign dq_rd = (!oe_n && !ce_n && rp_n) ? rd : ~rd;
	assign rb_low = cnt > 0;
	always @(posedge clk) begin
		we_d <= we_n;
		if (!rp_n) begin
			sr <= 8'h00;
			stat <= 1'b0;
			setup <= 1'b0;
			if (cnt > 0) aborted <= 1'b1;
		end else begin
			if (cnt > 0) cnt <= aborted ? 0 : cnt - 1;
			if (we_n && !we_d && !ce_n) begin
				log <= {log[23:0], dq};
				if (setup) begin
					setup <= 1'b0;
					if (dq != 8'hD0) sr <= sr | 8'h30;
					else sr <= sr | err;
					aborted <= 1'b0;
					if (dq == 8'hD0 && fault[0] == fault[1]) cnt <= BUSY;
				end else begin
					case (dq)
						8'h60: setup <= 1'b1;
						8'h70: stat <= 1'b1;
						8'h50: sr <= 8'h00;
						8'hFF: stat <= 1'b0;
						default: ;
					endcase
				end
				if (dq == 8'h60) stat <= 1'b1;
			end
		end
	end
endmodule

// ===== sim/flcc_tb.sv
/*
 * self-checking bench for flcc_top with a flash model.
 * assumes a 25 MHz clk and the register map of flcc_defines.vh.
 */
`timescale 1ns/10ps
`include "flcc_defines.vh"
module testbench;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg [3:0] awaddr = 4'h0, araddr = 4'h0;
	reg [31:0] wdata = 32'h0;
	reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg [1:0] fault = 2'h0, rr;
	wire awready, wready, bvalid, arready, rvalid, ce_n, we_n, oe_n, rp_n, dq_oe, rb_low;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] dq_out, dq_in;
	wire [7:0] bus = dq_oe ? dq_out : dq_in;
	// pull-up on the open-drain line
	wire rb_pin = rb_low ? 1'b0 : 1'b1;
	integer error_cnt = 0, cmp_count = 0;
	reg clk_en = 1'b1;
	flcc_top dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
		.reset_powerdown_n_pin(rp_n), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
		.flash_dq_oe(dq_oe), .ready_busy_n_pin(rb_pin));
	flcc_flash #(.BUSY(40)) flash (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.rp_n(rp_n), .dq(bus), .fault(fault), .dq_rd(dq_in), .rb_low(rb_low));
	initial begin
		forever #20 clk = ~clk;
	end
	// ****************
	// shared tasks
	// ****************
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test;
		if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task axw(input [3:0] a, input [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rr = bresp;
		bready <= 1'b0;
	endtask
	task axr(input [3:0] a, output [31:0] d);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	// busy is polled, so no fixed latency is assumed
	task run(input [1:0] op);
		reg [31:0] s;
		axw(`FLCC_REG_CTRL, {29'h0, op, 1'b1});
		chk("write resp", {30'h0, rr}, 32'h0);
		do axr(`FLCC_REG_STAT, s);
		while (s[0] !== 1'b0);
	endtask
	// ****************
	// scenarios
	// ****************
	task t_clear_ok;
		reg [31:0] v;
		run(`FLCC_OP_CLEAR_LOCKS);
		axr(`FLCC_REG_FSTAT, v);
		chk("flash status", v, 32'h80);
		chk("command order", flash.log, 32'h60D070FF);
		axr(`FLCC_REG_WDATA, v);
		chk("last command", v, 32'hFF);
		axr(4'h2, v);
		chk("unmapped data", v, 32'h0);
		chk("unmapped resp", {30'h0, rr}, 32'h2);
		axw(4'h2, 32'h0);
		chk("unmapped write", {30'h0, rr}, 32'h2);
		// a frozen enable must hold the strobe low past its usual span
		axw(`FLCC_REG_CTRL, {29'h0, `FLCC_OP_READ_ARRAY, 1'b1});
		while (we_n) @(posedge clk);
		clk_en <= 1'b0;
		repeat (20) @(posedge clk);
		chk("frozen strobe", {31'h0, we_n}, 32'h0);
		clk_en <= 1'b1;
		do axr(`FLCC_REG_STAT, v);
		while (v[0] !== 1'b0);
		chk("array order", flash.log, 32'hD070FFFF);
		axr(`FLCC_REG_CTRL, v);
		chk("control readback", v, 32'h6);
	endtask
	task t_fault(input [1:0] f, input [7:0] e);
		reg [31:0] v;
		fault <= f;
		run(`FLCC_OP_CLEAR_LOCKS);
		axr(`FLCC_REG_FSTAT, v);
		chk("error status", v, {24'h0, e});
		run(`FLCC_OP_CLEAR_LOCKS);
		axr(`FLCC_REG_STAT, v);
		chk("refused retry", {28'h0, v[3:0]}, 32'hE);
		run(`FLCC_OP_READ_STATUS);
		chk("sticky bits", {24'h0, flash.sr}, {25'h0, e[6:0]});
		axr(`FLCC_REG_FSTAT, v);
		chk("host sticky", v, {24'h0, e});
		fault <= 2'h0;
		// clear before the retry
		run(`FLCC_OP_CLEAR_STATUS);
		run(`FLCC_OP_CLEAR_LOCKS);
		axr(`FLCC_REG_FSTAT, v);
		chk("retry status", v, 32'h80);
	endtask
	task t_abort;
		reg [31:0] v;
		fault <= 2'h3;
		axw(`FLCC_REG_CTRL, 32'h1);
		while (rb_pin) @(posedge clk);
		axw(`FLCC_REG_CTRL, 32'h8);
		while (rp_n) @(posedge clk);
		chk("busy in reset", {31'h0, rb_pin}, 32'h0);
		while (!rp_n) @(posedge clk);
		repeat (2) @(posedge clk);
		chk("aborted", {31'h0, flash.aborted}, 32'h1);
		chk("status wiped", {24'h0, flash.sr}, 32'h0);
		do axr(`FLCC_REG_STAT, v);
		while (v[0] !== 1'b0);
		fault <= 2'h0;
		run(`FLCC_OP_CLEAR_LOCKS);
		axr(`FLCC_REG_FSTAT, v);
		chk("reissued", v, 32'h80);
		chk("reissue order", flash.log, 32'h60D070FF);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_clear_ok;
		t_fault(2'h1, 8'hA8);
		t_fault(2'h2, 8'h82);
		t_fault(2'h3, 8'hA0);
		t_abort;
		finish_test;
	end
	// about twenty times the expected run
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test;
	end
endmodule
